// *** hdl/sdcr_regs.svh ***
// Offsets, field positions and reset values of the socket DMA registers
`ifndef SDCR_REGS_SVH
`define SDCR_REGS_SVH
`define SDCR_OFF_PIN 8'h94
`define SDCR_OFF_CTL 8'h98
`define SDCR_PIN_LSB 0
`define SDCR_PIN_MSB 1
`define SDCR_EN_BIT 0
`define SDCR_WID_LSB 1
`define SDCR_WID_MSB 2
`define SDCR_EXT_BIT 3
`define SDCR_BASE_LSB 4
`define SDCR_BASE_MSB 15
`define SDCR_PIN_RST 2'h0
`define SDCR_WID_RST 2'h0
`define SDCR_BASE_RST 12'h000
`define SDCR_EN_RST 1'h0
`define SDCR_WORD_BYTES 3'h4
`endif

// *** hdl/sdcr_pkg.sv ***
// Types for the socket DMA configuration block
package sdcr_pkg;
  typedef enum logic [1:0] {
    SDCR_PIN_NONE = 2'h0,
    SDCR_PIN_SPKR = 2'h1,
    SDCR_PIN_IOIS16 = 2'h2,
    SDCR_PIN_INPACK = 2'h3
  } sdcr_pin_t;
  typedef enum logic [1:0] {
    SDCR_WID_8 = 2'h0,
    SDCR_WID_16 = 2'h1
  } sdcr_wid_t;
  // Gray along idle -> fetch -> drain
  typedef enum logic [1:0] {
    SDCR_PF_IDLE = 2'h0,
    SDCR_PF_FETCH = 2'h1,
    SDCR_PF_DRAIN = 2'h3
  } sdcr_pf_t;
  typedef struct packed {
    logic [1:0][1:0] pin;
    logic [1:0][11:0] base;
    logic [1:0][1:0] wid;
    logic [1:0] en;
    sdcr_pf_t pf;
    logic [31:0] pf_data;
    logic [2:0] pf_rem;
    logic [15:0] card_data;
    logic card_valid;
    logic [31:0] rdata;
    logic rvalid;
  } sdcr_state_t;
endpackage

// *** hdl/sdcr_top.sv ***
// Socket DMA configuration registers, window decode and prefetch
//
// Overview of operation
// - Pin-select register at 0x94 per socket; two low bits read/write.
// - Pin select 00 none, 01 speaker, 10 IOIS16, 11 INPACK.
// - Reserved bits of both registers read zero, writes ignored.
// - Writable fields cleared only by the global reset.
// - Control register at 0x98, reset zero: base, ext flag, width, enable.
// - Bits 15..4 form the base of a 16-bit I/O address.
// - Low four base bits are zero and not decoded: 16-byte aligned window.
// - Window decoded only while decode enable bit 0 is set.
// - Extended addressing bit 3 always reads zero.
// - Bits 2..1 set card width: 00 8-bit, 01 16-bit.
// - No card transfer is wider than 16 bits.
// - 32 bits prefetched from the host for two 16-bit or four 8-bit card transfers.
`timescale 1ns/100ps
`default_nettype none
`include "sdcr_regs.svh"
module sdcr_top
  import sdcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sec_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic io_valid,
  input wire logic [31:0] io_addr,
  output logic [1:0] io_hit,
  output logic [3:0] io_reg_sel,
  input wire logic [1:0] card_spkr,
  input wire logic [1:0] card_iois16,
  input wire logic [1:0] card_inpack,
  output logic [1:0] card_dreq,
  output logic [1:0] card_wide,
  input wire logic dma_active,
  input wire logic dma_sock,
  output logic pf_req,
  input wire logic pf_valid,
  input wire logic [31:0] pf_data,
  input wire logic card_strobe,
  output logic [15:0] card_data,
  output logic card_valid,
  output logic pf_empty
);

  sdcr_state_t s_q;
  sdcr_state_t s_d;

  function automatic logic route_dreq(input logic [1:0] sel,
      input logic spkr, input logic iois, input logic inp);
    case (sel)
      SDCR_PIN_NONE: route_dreq = 1'b0;
      SDCR_PIN_SPKR: route_dreq = spkr;
      SDCR_PIN_IOIS16: route_dreq = iois;
      default: route_dreq = inp;
    endcase
  endfunction

  // Upper half of the address must be zero, low nibble is don't-care
  function automatic logic win_hit(input logic [31:0] a,
      input logic [11:0] b, input logic en);
    win_hit = en && a[31:16] == 16'h0000 && a[15:4] == b;
  endfunction

  function automatic logic [31:0] read_reg(input sdcr_state_t s,
      input logic f, input logic [7:0] a);
    read_reg = 32'h0000_0000;
    if (a == `SDCR_OFF_PIN) begin
      read_reg[`SDCR_PIN_MSB:`SDCR_PIN_LSB] = s.pin[f];
    end else if (a == `SDCR_OFF_CTL) begin
      read_reg[`SDCR_BASE_MSB:`SDCR_BASE_LSB] = s.base[f];
      read_reg[`SDCR_WID_MSB:`SDCR_WID_LSB] = s.wid[f];
      read_reg[`SDCR_EN_BIT] = s.en[f];
      read_reg[`SDCR_EXT_BIT] = 1'b0;
    end
  endfunction

  logic w16;
  logic [2:0] step;
  assign w16 = s_q.wid[dma_sock] == SDCR_WID_16;
  // Reserved width codes fall back to byte transfers
  assign step = w16 ? 3'h2 : 3'h1;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = cfg_rd;
    s_d.card_valid = 1'b0;
    if (cfg_rd) begin
      s_d.rdata = read_reg(s_q, cfg_func, cfg_addr);
    end
    // Only bits with storage are written; the rest stay zero
    if (cfg_wr && cfg_addr == `SDCR_OFF_PIN && cfg_be[0]) begin
      s_d.pin[cfg_func] = cfg_wdata[`SDCR_PIN_MSB:`SDCR_PIN_LSB];
    end
    if (cfg_wr && cfg_addr == `SDCR_OFF_CTL) begin
      if (cfg_be[0]) begin
        s_d.en[cfg_func] = cfg_wdata[`SDCR_EN_BIT];
        s_d.wid[cfg_func] = cfg_wdata[`SDCR_WID_MSB:`SDCR_WID_LSB];
        s_d.base[cfg_func][3:0] = cfg_wdata[7:4];
      end
      if (cfg_be[1]) begin
        s_d.base[cfg_func][11:4] = cfg_wdata[15:8];
      end
    end
    case (s_q.pf)
      SDCR_PF_IDLE: begin
        if (dma_active && s_q.pin[dma_sock] != SDCR_PIN_NONE) begin
          s_d.pf = SDCR_PF_FETCH;
        end
      end
      SDCR_PF_FETCH: begin
        if (pf_valid) begin
          s_d.pf_data = pf_data;
          s_d.pf_rem = `SDCR_WORD_BYTES;
          s_d.pf = SDCR_PF_DRAIN;
        end
      end
      SDCR_PF_DRAIN: begin
        if (card_strobe) begin
          s_d.card_valid = 1'b1;
          // Never more than one halfword per card cycle
          s_d.card_data = w16 ? s_q.pf_data[15:0]
                                : {8'h00, s_q.pf_data[7:0]};
          s_d.pf_data = w16 ? {16'h0000, s_q.pf_data[31:16]}
                              : {8'h00, s_q.pf_data[31:8]};
          s_d.pf_rem = s_q.pf_rem - step;
          if (s_q.pf_rem <= step) begin
            s_d.pf = dma_active ? SDCR_PF_FETCH : SDCR_PF_IDLE;
          end
        end
      end
      default: s_d.pf = SDCR_PF_IDLE;
    endcase
    // Secondary reset stops the engine but spares the registers
    if (sec_rst) begin
      s_d.pf = SDCR_PF_IDLE;
      s_d.pf_rem = 3'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.pin <= {2{`SDCR_PIN_RST}};
      s_q.base <= {2{`SDCR_BASE_RST}};
      s_q.wid <= {2{`SDCR_WID_RST}};
      s_q.en <= {2{`SDCR_EN_RST}};
      s_q.pf <= SDCR_PF_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      io_hit[i] = io_valid && win_hit(io_addr, s_q.base[i], s_q.en[i]);
      card_dreq[i] = route_dreq(s_q.pin[i], card_spkr[i],
                                card_iois16[i], card_inpack[i]);
      card_wide[i] = s_q.wid[i] == SDCR_WID_16;
    end
  end

  assign io_reg_sel = io_addr[3:0];
  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign pf_req = s_q.pf == SDCR_PF_FETCH;
  assign pf_empty = s_q.pf != SDCR_PF_DRAIN;
  assign card_data = s_q.card_data;
  assign card_valid = s_q.card_valid;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_pin;
    cfg_rd && cfg_addr == `SDCR_OFF_PIN;
  endsequence
  sequence s_rd_ctl;
    cfg_rd && cfg_addr == `SDCR_OFF_CTL;
  endsequence
  sequence s_load;
    pf_req && pf_valid;
  endsequence
  sequence s_two_halves;
    card_strobe && w16 && !sec_rst ##1 card_strobe && w16 && !sec_rst;
  endsequence

  a_pin_rsvd_zero: assert property (
    s_rd_pin |=> cfg_rvalid && cfg_rdata[31:2] == 30'h0)
    else $error("pin select reserved bits not zero");
  a_ctl_rsvd_zero: assert property (
    s_rd_ctl |=> cfg_rdata[31:16] == 16'h0 && !cfg_rdata[3])
    else $error("control reserved or extended bit set");
  a_pin_write: assert property (
    cfg_wr && cfg_be[0] && cfg_addr == `SDCR_OFF_PIN ##1
      cfg_rd && cfg_addr == `SDCR_OFF_PIN
      && cfg_func == $past(cfg_func) && !cfg_wr
    |=> cfg_rdata[1:0] == $past(cfg_wdata[1:0], 2))
    else $error("pin select readback mismatch");
  a_soft_keep: assert property (
    sec_rst && !cfg_wr |=> $stable(s_q.base) && $stable(s_q.en)
      && $stable(s_q.pin) && $stable(s_q.wid))
    else $error("secondary reset changed registers");
  a_decode_off: assert property (
    !s_q.en[0] |-> !io_hit[0])
    else $error("window decoded while disabled");
  a_decode_hit: assert property (
    io_valid && s_q.en[1] && io_addr[31:16] == 16'h0
      && io_addr[15:4] == s_q.base[1] |-> io_hit[1])
    else $error("enabled window missed");
  a_dreq_route: assert property (
    s_q.pin[0] == SDCR_PIN_INPACK |-> card_dreq[0] == card_inpack[0])
    else $error("request pin routed wrongly");
  a_byte_narrow: assert property (
    card_strobe && !w16 && s_q.pf == SDCR_PF_DRAIN && !sec_rst
    |=> card_valid && card_data[15:8] == 8'h00)
    else $error("byte transfer carries upper data");
  a_prefetch_pair: assert property (
    (s_load and !sec_rst) ##1 s_two_halves
    |=> card_data == $past(pf_data[31:16], 3))
    else $error("second halfword not from prefetch");

  // Read strobe answered exactly one cycle later, never unasked
  a_rvalid_pulse: assert property (
    cfg_rd |=> cfg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_quiet: assert property (
    !cfg_rd |=> !cfg_rvalid)
    else $error("read answer without request");

  // Unmapped offsets must look empty to probing software
  a_unmapped_zero: assert property (
    cfg_rd && cfg_addr != `SDCR_OFF_PIN && cfg_addr != `SDCR_OFF_CTL
    |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped offset read nonzero");
  a_ctl_readback: assert property (
    cfg_wr && cfg_be[1:0] == 2'h3 && cfg_addr == `SDCR_OFF_CTL ##1
      cfg_rd && cfg_addr == `SDCR_OFF_CTL
      && cfg_func == $past(cfg_func) && !cfg_wr
    |=> cfg_rdata[15:0] == ($past(cfg_wdata[15:0], 2) & 16'hFFF7))
    else $error("control readback mismatch");
  a_wide_read: assert property (
    cfg_rd && !cfg_wr && cfg_addr == `SDCR_OFF_CTL && !cfg_func
    |=> card_wide[0] == (cfg_rdata[2:1] == 2'h1))
    else $error("width flag disagrees with register");

  // Window decode, both sockets
  a_decode_off1: assert property (
    !s_q.en[1] |-> !io_hit[1])
    else $error("window decoded while disabled");
  a_decode_hit0: assert property (
    io_valid && s_q.en[0] && io_addr[31:16] == 16'h0
      && io_addr[15:4] == s_q.base[0] |-> io_hit[0])
    else $error("enabled window missed");
  a_upper_miss: assert property (
    io_addr[31:16] != 16'h0000 |-> io_hit == 2'h0)
    else $error("hit above the lowest 64K");
  a_base_miss: assert property (
    io_addr[15:4] != s_q.base[0] |-> !io_hit[0])
    else $error("hit outside the 16-byte window");

  // Request routing for the remaining select codes
  a_dreq_none: assert property (
    s_q.pin[0] == SDCR_PIN_NONE |-> !card_dreq[0])
    else $error("request seen with no pin selected");
  a_dreq_spkr: assert property (
    s_q.pin[0] == SDCR_PIN_SPKR |-> card_dreq[0] == card_spkr[0])
    else $error("speaker pin routed wrongly");
  a_dreq_iois: assert property (
    s_q.pin[0] == SDCR_PIN_IOIS16 |-> card_dreq[0] == card_iois16[0])
    else $error("IOIS16 pin routed wrongly");

  // Prefetch engine; a stalled host must not lose the request
  a_word_load: assert property (
    (s_load and !sec_rst) |=> !pf_empty)
    else $error("loaded word not held");
  a_half_low: assert property (
    (s_load and !sec_rst) ##1 (card_strobe && w16 && !sec_rst)
    |=> card_data == $past(pf_data[15:0], 2))
    else $error("first halfword not from prefetch");
  a_req_hold: assert property (
    pf_req && !pf_valid && !sec_rst |=> pf_req)
    else $error("fetch request dropped before answer");
  a_strobe_refused: assert property (
    pf_empty && card_strobe |=> !card_valid)
    else $error("card transfer from empty buffer");
  // Idle engine waits for a configured request pin
  a_idle_stay: assert property (
    pf_empty && !pf_req
      && !(dma_active && s_q.pin[dma_sock] != SDCR_PIN_NONE)
    |=> !pf_req)
    else $error("engine left idle without a request pin");
  a_srst_idle: assert property (
    sec_rst |=> pf_empty && !pf_req)
    else $error("secondary reset left engine running");

endmodule
`default_nettype wire

// *** tb/sdcr_pf_model.sv ***
// Host-side prefetch word source that answers pf_req promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module sdcr_pf_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pf_req,
  input wire logic slow,
  input wire logic [31:0] word,
  output logic pf_valid,
  output logic [31:0] pf_data
);
  logic [1:0] cnt_q;
  // Data turns to the inverse once taken, so stale words never match
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      pf_valid <= 1'b0;
      pf_data <= 32'h0;
    end else if (pf_req && pf_valid) begin
      cnt_q <= 2'h0;
      pf_valid <= 1'b0;
      pf_data <= ~word;
    end else if (pf_req && cnt_q == (slow ? 2'h2 : 2'h0)) begin
      pf_valid <= 1'b1;
      pf_data <= word;
    end else if (pf_req) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Register, decode and prefetch tests for the socket DMA block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk = 0, rstn = 0, sec_rst = 0, cfg_wr = 0, cfg_rd = 0;
  logic cfg_func = 0, io_valid = 0, dma_active = 0, dma_sock = 0;
  logic card_strobe = 0, slow = 0;
  logic [7:0] cfg_addr = 8'h0;
  logic [3:0] cfg_be = 4'hF, io_reg_sel;
  logic [31:0] cfg_wdata = 32'h0, io_addr = 32'h0, word = 32'h0;
  logic [1:0] card_spkr = 2'h0, card_iois16 = 2'h0, card_inpack = 2'h0;
  logic [31:0] cfg_rdata, pf_data;
  logic cfg_rvalid, pf_req, pf_valid, card_valid, pf_empty;
  logic [1:0] io_hit, card_dreq, card_wide;
  logic [15:0] card_data;
  int err_count = 0, n_tests = 0, k, j;
  sdcr_top sdcr_top_i (.core_clk(core_clk), .rstn(rstn), .sec_rst(sec_rst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_valid(io_valid),
    .io_addr(io_addr), .io_hit(io_hit), .io_reg_sel(io_reg_sel),
    .card_spkr(card_spkr), .card_iois16(card_iois16),
    .card_inpack(card_inpack), .card_dreq(card_dreq),
    .card_wide(card_wide), .dma_active(dma_active), .dma_sock(dma_sock),
    .pf_req(pf_req), .pf_valid(pf_valid), .pf_data(pf_data),
    .card_strobe(card_strobe), .card_data(card_data),
    .card_valid(card_valid), .pf_empty(pf_empty));
  sdcr_pf_model sdcr_pf_model_i (.core_clk(core_clk), .rstn(rstn),
    .pf_req(pf_req), .slow(slow), .word(word), .pf_valid(pf_valid),
    .pf_data(pf_data));
  task wrap_up;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic f, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) #1;
    cfg_func = f; cfg_addr = a; cfg_wdata = d; cfg_wr = 1;
    @(posedge core_clk) #1;
    cfg_wr = 0;
  endtask
  task wrrd(input logic f, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e);
    @(posedge core_clk) #1;
    cfg_func = f; cfg_addr = a; cfg_wdata = d; cfg_wr = 1;
    @(posedge core_clk) #1;
    cfg_wr = 0; cfg_rd = 1;
    @(posedge core_clk) #1;
    cfg_rd = 0;
    chk("rvalid", 1, cfg_rvalid);
    chk("rdata", e, cfg_rdata);
  endtask
  task pair(input logic [31:0] e);
    int i;
    @(posedge core_clk) #1;
    for (i = 0; i < 20 && pf_empty !== 1'b0; i++) @(posedge core_clk) #1;
    chk("empty", 0, pf_empty);
    card_strobe = 1;
    @(posedge core_clk) #1;
    chk("cvalid", 1, card_valid);
    chk("card", e[15:0], card_data);
    @(posedge core_clk) #1;
    card_strobe = 0;
    chk("cvalid", 1, card_valid);
    chk("card", e[31:16], card_data);
  endtask
  task rd(input logic f, input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk) #1;
    cfg_func = f; cfg_addr = a; cfg_rd = 1;
    @(posedge core_clk) #1;
    cfg_rd = 0;
    chk("rvalid", 1, cfg_rvalid);
    chk("rdata", e, cfg_rdata);
  endtask
  task io(input logic [31:0] a, input logic [31:0] e);
    io_valid = 1; io_addr = a; #1;
    chk("hit", e, io_hit);
  endtask
  task xfer(input logic [15:0] e);
    int i;
    @(posedge core_clk) #1;
    for (i = 0; i < 20 && pf_empty !== 1'b0; i++) @(posedge core_clk) #1;
    chk("empty", 0, pf_empty);
    card_strobe = 1;
    @(posedge core_clk) #1;
    card_strobe = 0;
    chk("cvalid", 1, card_valid);
    chk("card", e, card_data);
  endtask
  task srst;
    @(posedge core_clk) #1 sec_rst = 1;
    @(posedge core_clk) #1 sec_rst = 0;
  endtask
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rstn = 1;
    rd(0, 8'h94, 0);
    rd(1, 8'h98, 0);
    wrrd(0, 8'h94, 32'hFFFFFFFF, 32'h3);
    wrrd(1, 8'h98, 32'hFFFFFFFF, 32'hFFF7);
    rd(0, 8'h98, 0);
    rd(0, 8'h9C, 0);
    srst;
    rd(1, 8'h98, 32'hFFF7);
    rd(0, 8'h94, 32'h3);
    for (k = 0; k < 4; k++) begin
      wr(0, 8'h94, k);
      for (j = 0; j < 3; j++) begin
        {card_inpack[0], card_iois16[0], card_spkr[0]} = 3'h1 << j;
        #1 chk("dreq", k != 0 && k == j + 1, card_dreq[0]);
      end
    end
    wr(0, 8'h98, 32'h1230);
    io(32'h1235, 0);
    wr(0, 8'h98, 32'h1231);
    io(32'h1235, 1);
    chk("sel", 5, io_reg_sel);
    io(32'h11235, 0);
    io(32'h1245, 0);
    io(32'h122F, 0);
    io(32'hFFF0, 2);
    wr(0, 8'h98, 32'h1233);
    wr(0, 8'h94, 1);
    #1 chk("wide", 1, card_wide);
    word = 32'h89ABCDEF;
    dma_active = 1;
    xfer(16'hCDEF);
    xfer(16'h89AB);
    chk("req", 1, pf_req);
    slow = 1;
    word = 32'h76543210;
    dma_active = 0;
    pair(32'h76543210);
    chk("req", 0, pf_req);
    srst;
    wr(0, 8'h98, 32'h1231);
    #1 chk("wide", 0, card_wide);
    word = 32'hA1B2C3D4;
    dma_active = 1;
    for (k = 0; k < 4; k++) begin
      if (k == 3) dma_active = 0;
      xfer({8'h0, word[8*k+:8]});
    end
    wrap_up;
  end
endmodule
`default_nettype wire
